/* hw/tpr_pkg.sv */
// shared constants, register map and helpers of the programmable ripple timer
package tpr_pkg;

  localparam int STAGES = 24;
  localparam int SECTION = 8;
  localparam int SECTIONS = 3;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int TIME_W = 16;

  // register byte addresses
  localparam logic [ADDR_W-1:0] CTRL_OFS = 5'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 5'h04;
  localparam logic [ADDR_W-1:0] COUNT_OFS = 5'h08;
  localparam logic [ADDR_W-1:0] PWIDTH_OFS = 5'h0c;
  localparam logic [ADDR_W-1:0] OSCHALF_OFS = 5'h10;

  // control register fields
  localparam int CTRL_SET_BIT = 0;
  localparam int CTRL_RESET_BIT = 1;
  localparam int CTRL_SKIP_BIT = 2;
  localparam int CTRL_HOLD_BIT = 3;
  localparam int CTRL_OSCSTOP_BIT = 4;
  localparam int CTRL_PULSE_BIT = 5;
  localparam int CTRL_INTOSC_BIT = 6;
  localparam int CTRL_FEEDBACK_BIT = 7;
  localparam int CTRL_SEL_LSB = 8;
  localparam int CTRL_W = 12;

  // status register fields
  localparam int STAT_OUT_BIT = 0;
  localparam int STAT_TEST_BIT = 1;
  localparam int STAT_LATCH_BIT = 2;

  // values after reset: the timer comes up held in reset
  localparam logic [CTRL_W-1:0] CTRL_RESET_VAL = 12'h002;
  localparam logic [TIME_W-1:0] PWIDTH_RESET_VAL = 16'h0004;
  localparam logic [TIME_W-1:0] OSCHALF_RESET_VAL = 16'h0008;

  localparam logic [4:0] BYPASS_BASE = 5'h00;
  localparam logic [4:0] NORMAL_BASE = 5'h08;

  typedef enum logic {TPR_MONO_IDLE, TPR_MONO_HIGH} tpr_mono_t;

  // bit index of the stage driving the output
  function automatic logic [4:0] tpr_stage_index(input logic skip, input logic [3:0] code);
    return (skip ? BYPASS_BASE : NORMAL_BASE) + {1'b0, code};
  endfunction

endpackage

/* hw/tpr_core_if.sv */
// connection between the timer front end and its counter core
`timescale 1ns/1ps
interface tpr_core_if;
  logic count_edge;
  logic set_in;
  logic reset_in;
  logic skip;
  logic hold;
  logic [3:0] sel;
  logic [tpr_pkg::STAGES-1:0] stages;
  logic level;
  logic latch;
  logic test_mode;

  modport core (
    input count_edge, set_in, reset_in, skip, hold, sel,
    output stages, level, latch, test_mode
  );
  modport ctrl (
    output count_edge, set_in, reset_in, skip, hold, sel,
    input stages, level, latch, test_mode
  );
endinterface

/* hw/tpr_core.sv */
// 24-stage counter with output latch and split test arrangement
`timescale 1ns/1ps
module tpr_core
  import tpr_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  tpr_core_if.core cif
);
  logic [STAGES-1:0] stages_reg;
  logic latch_reg;
  logic [STAGES-1:0] sect_inc;
  logic step;

  assign cif.test_mode = cif.set_in & cif.reset_in & cif.skip;
  assign step = cif.count_edge & ~cif.hold;
  assign cif.stages = stages_reg;
  assign cif.latch = latch_reg;
  assign cif.level = latch_reg | stages_reg[tpr_stage_index(cif.skip, cif.sel)];

  genvar g;
  generate
    for (g = 0; g < SECTIONS; g++)
    begin : g_sect
      assign sect_inc[g*SECTION +: SECTION] = stages_reg[g*SECTION +: SECTION] + 8'h01;
    end
  endgenerate

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      stages_reg <= '0;
    else if (clk_en)
    begin
      if (cif.test_mode)
      begin
        if (step)
          stages_reg <= sect_inc;
      end
      else if (cif.set_in || cif.reset_in)
        stages_reg <= '0;
      else if (step && !latch_reg)
        stages_reg <= stages_reg + 24'h000001;
    end
  end

  // the edge that clears the latch is not counted, as in the ripple original
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      latch_reg <= 1'b0;
    else if (clk_en)
    begin
      if (cif.reset_in)
        latch_reg <= 1'b0;
      else if (cif.set_in)
        latch_reg <= 1'b1;
      else if (step)
        latch_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  reset_clear_a: assert property (clk_en && cif.reset_in && !cif.set_in |=> stages_reg == '0 && !latch_reg) else $error("reset did not clear");
  set_force_a: assert property (clk_en && cif.set_in && !cif.reset_in |=> stages_reg == '0 && cif.level) else $error("set did not force high");
  hold_freeze_a: assert property (clk_en && cif.hold && !cif.set_in && !cif.reset_in |=> $stable(stages_reg) && $stable(latch_reg)) else $error("hold let counter move");
  test_split_a: assert property (clk_en && cif.test_mode && step |=> stages_reg[15:8] == $past(stages_reg[15:8]) + 8'h01 && stages_reg[7:0] == $past(stages_reg[7:0]) + 8'h01) else $error("sections not counting together");
  first_edge_a: assert property (clk_en && latch_reg && step && !cif.set_in && !cif.reset_in |=> !latch_reg && $stable(stages_reg)) else $error("first edge after set wrong");
  serial_wrap_a: assert property (clk_en && &stages_reg && step && !cif.set_in && !cif.reset_in && !latch_reg |=> stages_reg == '0 && !cif.level) else $error("all ones did not wrap");
  serial_step_a: assert property (clk_en && step && !cif.set_in && !cif.reset_in && !latch_reg |=> stages_reg == $past(stages_reg) + 24'h000001) else $error("serial step wrong");

  test_load_c: cover property (cif.test_mode && &stages_reg);
  wrap_c: cover property (&stages_reg ##1 stages_reg == '0);
  set_release_c: cover property (latch_reg ##1 !latch_reg);
endmodule

/* hw/tpr_top.sv */
// programmable ripple timer: avalon-mm registers, clock source, output shaping
//
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - set, reset and bypass all high split counter into three 8-stage sections
// - 255 test edges bring every stage to one and the output high
// - reset high with set low clears all stages and drives output low
// - one serial edge after test load wraps all ones to zeros, output low
// - set drives the output high, or keeps it high
// - while hold is high count edges change nothing
// - after set and hold release the first falling edge drives output low
// - free running output divides count clock by two to the n
// - both drive outputs carry an undivided copy of the count clock
// - reset high at power-up starts output low; release enables counting
// - after reset falls output rises on falling edge number 2^n/2
// - pulse shaping gives fixed-width pulses repeating every 2^n clocks
// - output fed to oscillator stop is driven low by reset, freeing oscillator
// - oscillator stays stopped while reset is high
// - in feedback use output stays low 2^n/2 periods then rises, stopping
// - oscillator stop high stops all count edges for standby
// - set clears stages and forces output high; reset clears and forces low
// - select code picks stage 9 plus code, or 1 plus code with bypass
// - test arrangement only while bypass, set and reset are all high
module tpr_top
  import tpr_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [tpr_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [tpr_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [tpr_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic count_clock_input,
  output logic osc_drive_a,
  output logic osc_drive_b,
  output logic selected_stage_output
);
  import tpr_pkg::*;

  tpr_core_if cif ();

  logic [CTRL_W-1:0] ctrl_reg;
  logic [TIME_W-1:0] pwidth_reg;
  logic [TIME_W-1:0] oschalf_reg;
  logic [DATA_W-1:0] readdata_reg;
  logic waitrequest_reg;
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic src_prev_reg;
  logic osc_level_reg;
  logic [TIME_W-1:0] osc_cnt_reg;
  logic drive_reg;
  logic out_reg;
  logic level_prev_reg;
  tpr_mono_t mono_reg;
  logic [TIME_W-1:0] mono_cnt_reg;
  logic req;
  logic accept;
  logic src_level;
  logic osc_stop_eff;
  logic osc_run;
  logic src_fall;
  logic pulse_en;
  logic [TIME_W-1:0] width_eff;

  // merge write data into a register under the byte enables
  function automatic logic [DATA_W-1:0] be_merge(input logic [DATA_W-1:0] old_val,
                                                 input logic [DATA_W-1:0] new_val,
                                                 input logic [3:0] be);
    logic [DATA_W-1:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        res[i*8 +: 8] = new_val[i*8 +: 8];
    end
    return res;
  endfunction

  // ---------------- bus slave ----------------
  // every access takes one wait cycle: waitrequest drops for exactly one cycle
  assign req = avs_read | avs_write;
  assign accept = req & ~waitrequest_reg;

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      waitrequest_reg <= 1'b1;
    else if (clk_en)
    begin
      if (req && waitrequest_reg)
        waitrequest_reg <= 1'b0;
      else
        waitrequest_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      readdata_reg <= '0;
    else if (clk_en)
    begin
      if (avs_read && waitrequest_reg)
      begin
        case (avs_address)
          CTRL_OFS: readdata_reg <= {{(DATA_W-CTRL_W){1'b0}}, ctrl_reg};
          STATUS_OFS: readdata_reg <= {29'h0, cif.latch, cif.test_mode, out_reg};
          COUNT_OFS: readdata_reg <= {8'h00, cif.stages};
          PWIDTH_OFS: readdata_reg <= {16'h0000, pwidth_reg};
          OSCHALF_OFS: readdata_reg <= {16'h0000, oschalf_reg};
          default: readdata_reg <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      ctrl_reg <= CTRL_RESET_VAL;
    else if (clk_en && accept && avs_write && avs_address == CTRL_OFS)
      ctrl_reg <= CTRL_W'(be_merge({{(DATA_W-CTRL_W){1'b0}}, ctrl_reg}, avs_writedata,
                                   avs_byteenable));
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      pwidth_reg <= PWIDTH_RESET_VAL;
    else if (clk_en && accept && avs_write && avs_address == PWIDTH_OFS)
      pwidth_reg <= TIME_W'(be_merge({16'h0000, pwidth_reg}, avs_writedata, avs_byteenable));
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      oschalf_reg <= OSCHALF_RESET_VAL;
    else if (clk_en && accept && avs_write && avs_address == OSCHALF_OFS)
      oschalf_reg <= TIME_W'(be_merge({16'h0000, oschalf_reg}, avs_writedata, avs_byteenable));
  end

  // ---------------- count clock source ----------------
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      pin_meta_reg <= count_clock_input;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // the feedback option lets the timed-out output park the oscillator
  assign osc_stop_eff = ctrl_reg[CTRL_OSCSTOP_BIT] |
                        (ctrl_reg[CTRL_FEEDBACK_BIT] & out_reg);
  assign osc_run = ~(osc_stop_eff | ctrl_reg[CTRL_RESET_BIT] | ctrl_reg[CTRL_SET_BIT]);

  // on-chip oscillator stands in for the rc network; it halts high, as the
  // clock input idles in the stopped state, so restarting costs no spurious edge
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      osc_level_reg <= 1'b1;
      osc_cnt_reg <= '0;
    end
    else if (clk_en)
    begin
      if (!osc_run)
      begin
        osc_level_reg <= 1'b1;
        osc_cnt_reg <= '0;
      end
      else if (osc_cnt_reg + 16'h0001 >= oschalf_reg)
      begin
        osc_level_reg <= ~osc_level_reg;
        osc_cnt_reg <= '0;
      end
      else
        osc_cnt_reg <= osc_cnt_reg + 16'h0001;
    end
  end

  assign src_level = ctrl_reg[CTRL_INTOSC_BIT] ? osc_level_reg : pin_sync_reg;
  // an external clock is also gated by the stop bit
  assign src_fall = src_prev_reg & ~src_level & ~osc_stop_eff;

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      src_prev_reg <= 1'b0;
      drive_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      src_prev_reg <= src_level;
      drive_reg <= src_level;
    end
  end

  assign osc_drive_a = drive_reg;
  assign osc_drive_b = drive_reg;

  // ---------------- counter core ----------------
  assign cif.count_edge = src_fall;
  assign cif.set_in = ctrl_reg[CTRL_SET_BIT];
  assign cif.reset_in = ctrl_reg[CTRL_RESET_BIT];
  assign cif.skip = ctrl_reg[CTRL_SKIP_BIT];
  assign cif.hold = ctrl_reg[CTRL_HOLD_BIT];
  assign cif.sel = ctrl_reg[CTRL_SEL_LSB +: 4];

  tpr_core u_core (
    .clock(clock),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .cif(cif)
  );

  // ---------------- output shaping ----------------
  assign pulse_en = ctrl_reg[CTRL_PULSE_BIT];
  assign width_eff = (pwidth_reg == '0) ? 16'h0001 : pwidth_reg;

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      level_prev_reg <= 1'b0;
    else if (clk_en)
      level_prev_reg <= cif.level;
  end

  // one pulse per rising decoded level; a rise during a pulse is absorbed
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      mono_reg <= TPR_MONO_IDLE;
      mono_cnt_reg <= '0;
    end
    else if (clk_en)
    begin
      case (mono_reg)
        TPR_MONO_IDLE:
        begin
          if (pulse_en && cif.level && !level_prev_reg)
          begin
            mono_reg <= TPR_MONO_HIGH;
            mono_cnt_reg <= width_eff;
          end
        end
        TPR_MONO_HIGH:
        begin
          if (!pulse_en || mono_cnt_reg == 16'h0001)
          begin
            mono_reg <= TPR_MONO_IDLE;
            mono_cnt_reg <= '0;
          end
          else
            mono_cnt_reg <= mono_cnt_reg - 16'h0001;
        end
        default:
        begin
          mono_reg <= TPR_MONO_IDLE;
          mono_cnt_reg <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      out_reg <= 1'b0;
    else if (clk_en)
    begin
      if (!pulse_en)
        out_reg <= cif.level;
      else
        out_reg <= (mono_reg == TPR_MONO_IDLE) ? (cif.level && !level_prev_reg)
                                                : (mono_cnt_reg != 16'h0001);
    end
  end

  assign selected_stage_output = out_reg;
  assign avs_readdata = readdata_reg;
  assign avs_waitrequest = waitrequest_reg;

  // ---------------- checks ----------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  stopped_osc_a: assert property (clk_en && !osc_run |=> osc_level_reg && !(clk_en && src_fall && ctrl_reg[CTRL_INTOSC_BIT] && !osc_run)) else $error("oscillator ran while stopped");
  stop_no_edge_a: assert property (osc_stop_eff |-> !src_fall) else $error("count edge during stop");
  drive_copy_a: assert property (clk_en |=> osc_drive_a == $past(src_level) && osc_drive_b == osc_drive_a) else $error("drive outputs not a copy");
  direct_out_a: assert property (clk_en && !pulse_en |=> selected_stage_output == $past(cif.level)) else $error("output not following stage");
  reset_low_a: assert property (clk_en && cif.reset_in && !cif.set_in ##1 clk_en |=> !selected_stage_output) else $error("reset left output high");
  pulse_start_a: assert property (clk_en && pulse_en && mono_reg == TPR_MONO_IDLE && cif.level && !level_prev_reg |=> selected_stage_output && mono_reg == TPR_MONO_HIGH && mono_cnt_reg == $past(width_eff)) else $error("pulse did not start");
  bus_ack_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low twice");
  bus_answer_a: assert property (clk_en && req && avs_waitrequest |=> !avs_waitrequest) else $error("request not answered");

  pulse_c: cover property (pulse_en && mono_reg == TPR_MONO_HIGH ##1 mono_reg == TPR_MONO_IDLE);
  feedback_c: cover property (ctrl_reg[CTRL_FEEDBACK_BIT] && $rose(out_reg));
endmodule

/* verif/tpr_clk_src.sv */
// count clock source model: sends a burst of falling edges on the count pin
`timescale 1ns/1ps
module tpr_clk_src (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic go,
  input wire logic [15:0] n_edges,
  input wire logic idle_level,
  output logic pin,
  output logic busy
);
  logic [15:0] left_reg;
  logic [2:0] phase_reg;
  // four clocks low then four high, twice the minimum the synchroniser needs
  assign pin = busy ? phase_reg[2] : idle_level;
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      busy <= 1'b0;
      phase_reg <= 3'h0;
      left_reg <= 16'h0000;
    end
    else if (!busy)
    begin
      busy <= go && (n_edges != 16'h0000);
      left_reg <= n_edges;
      phase_reg <= 3'h0;
    end
    else
    begin
      phase_reg <= phase_reg + 3'h1;
      if (phase_reg == 3'h7)
      begin
        left_reg <= left_reg - 16'h0001;
        busy <= (left_reg != 16'h0001);
      end
    end
  end
endmodule

/* verif/tb.sv */
// self-checking bench of the programmable ripple timer
`timescale 1ns/1ps
module tb;
  import tpr_pkg::*;
  typedef struct {logic skip; logic [3:0] code; int half;} tpr_row_t;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic count_clock_input;
  logic osc_drive_a;
  logic osc_drive_b;
  logic selected_stage_output;
  logic go = 1'b0;
  logic [15:0] n_edges = 16'h0000;
  logic idle_level = 1'b1;
  logic busy;
  logic prev_out = 1'b0;
  logic [DATA_W-1:0] rd;
  int failures = 0;
  int n_compared = 0;
  int hi_len = 0;
  int gap = 0;
  int last_w = 0;
  int last_p = 0;
  int t;
  // skip, code, edges until the output first rises
  tpr_row_t rows[5] = '{'{1'b1, 4'h0, 1}, '{1'b1, 4'h3, 8}, '{1'b1, 4'h7, 128},
                        '{1'b0, 4'h0, 256}, '{1'b0, 4'h1, 512}};

  always #2 clock = ~clock;

  tpr_top u_tpr_top (
    .clock(clock),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .count_clock_input(count_clock_input),
    .osc_drive_a(osc_drive_a),
    .osc_drive_b(osc_drive_b),
    .selected_stage_output(selected_stage_output)
  );

  tpr_clk_src u_tpr_clk_src (
    .clock(clock),
    .reset_n(reset_n),
    .go(go),
    .n_edges(n_edges),
    .idle_level(idle_level),
    .pin(count_clock_input),
    .busy(busy)
  );

  // pulse width and spacing of the output, in system clocks
  always @(posedge clock)
  begin
    prev_out <= selected_stage_output;
    gap <= gap + 1;
    if (selected_stage_output === 1'b1)
      hi_len <= hi_len + 1;
    if (selected_stage_output === 1'b1 && prev_out !== 1'b1)
    begin
      last_p <= gap;
      gap <= 1;
      hi_len <= 1;
    end
    if (selected_stage_output !== 1'b1 && prev_out === 1'b1)
      last_w <= hi_len;
  end

  task automatic give_verdict();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // entered just after a rising edge; returns one edge after the release
  // no local limit: a slave that never answers is caught by the watchdog
  task automatic bus_xfer(input logic wr, input logic [ADDR_W-1:0] a,
                          input logic [31:0] d, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0)
      @(posedge clock);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    bus_xfer(1'b1, a, d, 4'hf);
  endtask

  task automatic rd_check(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    bus_xfer(1'b0, a, 32'h0, 4'hf);
    check(rd, exp);
  endtask

  // n falling edges, then enough clocks for sync, count and output to settle
  task automatic edges(input int n);
    if (n > 0)
    begin
      n_edges <= n[15:0];
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      @(posedge clock);
      while (busy !== 1'b0)
        @(posedge clock);
    end
    repeat (6) @(posedge clock);
  endtask

  initial
  begin
    repeat (60000) @(posedge clock);
    failures++;
    $display("unexpected at %0t: watchdog expired", $time);
    give_verdict();
  end

  initial
  begin
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    check(selected_stage_output, 32'h0);
    rd_check(CTRL_OFS, 32'h0000_0002);
    rd_check(PWIDTH_OFS, 32'h0000_0004);
    rd_check(OSCHALF_OFS, 32'h0000_0008);
    edges(3);
    rd_check(COUNT_OFS, 32'h0);
    bus_xfer(1'b1, STATUS_OFS, 32'hffff_ffff, 4'hf);
    rd_check(STATUS_OFS, 32'h0);
    bus_xfer(1'b1, 5'h14, 32'hffff_ffff, 4'hf);
    rd_check(5'h14, 32'h0);
    foreach (rows[i])
    begin
      wr(CTRL_OFS, {20'h0, rows[i].code, 5'h00, rows[i].skip, 2'b10});
      edges(0);
      check(selected_stage_output, 32'h0);
      rd_check(COUNT_OFS, 32'h0);
      wr(CTRL_OFS, {20'h0, rows[i].code, 5'h00, rows[i].skip, 2'b00});
      edges(rows[i].half - 1);
      check(selected_stage_output, 32'h0);
      edges(1);
      check(selected_stage_output, 32'h1);
      edges(rows[i].half);
      check(selected_stage_output, 32'h0);
      rd_check(COUNT_OFS, 2 * rows[i].half);
    end
    // cleared first, then split into three sections
    wr(CTRL_OFS, 32'h0000_0706);
    wr(CTRL_OFS, 32'h0000_0707);
    bus_xfer(1'b0, STATUS_OFS, 32'h0, 4'hf);
    check(rd & 32'h3, 32'h2);
    edges(254);
    rd_check(COUNT_OFS, 32'h00fe_fefe);
    edges(1);
    rd_check(COUNT_OFS, 32'h00ff_ffff);
    check(selected_stage_output, 32'h1);
    wr(CTRL_OFS, 32'h0000_0700);
    edges(0);
    check(selected_stage_output, 32'h1);
    edges(1);
    rd_check(COUNT_OFS, 32'h0);
    check(selected_stage_output, 32'h0);
    wr(CTRL_OFS, 32'h0000_0009);
    edges(0);
    check(selected_stage_output, 32'h1);
    rd_check(COUNT_OFS, 32'h0);
    wr(CTRL_OFS, 32'h0000_0008);
    idle_level <= 1'b0;
    edges(0);
    check({osc_drive_a, osc_drive_b}, 32'h0);
    idle_level <= 1'b1;
    edges(3);
    check({osc_drive_a, osc_drive_b}, 32'h3);
    check(selected_stage_output, 32'h1);
    rd_check(COUNT_OFS, 32'h0);
    wr(CTRL_OFS, 32'h0000_0000);
    edges(1);
    check(selected_stage_output, 32'h0);
    rd_check(COUNT_OFS, 32'h0);
    edges(1);
    rd_check(COUNT_OFS, 32'h1);
    // with the enable low the pin burst must leave no trace, synchroniser included
    clk_en <= 1'b0;
    edges(2);
    clk_en <= 1'b1;
    edges(0);
    rd_check(COUNT_OFS, 32'h1);
    wr(CTRL_OFS, 32'h0000_0010);
    edges(3);
    rd_check(COUNT_OFS, 32'h1);
    // internal oscillator with the output fed back to its stop input
    wr(CTRL_OFS, 32'h0000_01c5);
    edges(0);
    check(selected_stage_output, 32'h1);
    wr(CTRL_OFS, 32'h0000_01c6);
    edges(0);
    check(selected_stage_output, 32'h0);
    repeat (40) @(posedge clock);
    rd_check(COUNT_OFS, 32'h0);
    wr(CTRL_OFS, 32'h0000_01c4);
    t = 0;
    while (selected_stage_output !== 1'b1 && t < 200)
    begin
      @(posedge clock);
      t++;
    end
    check(t >= 16 && t <= 40, 32'h1);
    repeat (64) @(posedge clock);
    rd_check(COUNT_OFS, 32'h2);
    check(selected_stage_output, 32'h1);
    // low lane only, so the width becomes 6
    bus_xfer(1'b1, PWIDTH_OFS, 32'h0000_0506, 4'h1);
    rd_check(PWIDTH_OFS, 32'h0000_0006);
    wr(CTRL_OFS, 32'h0000_0026);
    wr(CTRL_OFS, 32'h0000_0024);
    edges(6);
    check(last_w, 32'd6);
    check(last_p, 32'd16);
    // second reset in mid-run: control returns to its held-in-reset value
    reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    check(selected_stage_output, 32'h0);
    rd_check(CTRL_OFS, 32'h0000_0002);
    rd_check(COUNT_OFS, 32'h0);
    edges(2);
    rd_check(COUNT_OFS, 32'h0);
    give_verdict();
  end
endmodule
